// ==== psr_cfg.svh ====
`ifndef PSR_CFG_SVH
`define PSR_CFG_SVH

// ----------------------------------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------------------------------
`define PSR_IDX_STATUS 8'h01
`define PSR_IDX_ID_HIGH 8'h02
`define PSR_IDX_PARTNER 8'h05
`define PSR_IDX_EXT_CTRL 8'h10
`define PSR_IDX_DETAIL 8'h11
`define PSR_IDX_TEN_OPS 8'h12
`define PSR_IDX_IRQ_STATUS 8'h20
`define PSR_IDX_IRQ_MASK 8'h21

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PSR_ST_AN_CPLT 5
`define PSR_ST_RFAULT 4
`define PSR_ST_AN_ABLE 3
`define PSR_ST_LINK 2
`define PSR_ST_JABBER 1
`define PSR_ST_EXT_CAP 0
`define PSR_DT_JABBER 2
`define PSR_DT_RFAULT 1
`define PSR_DT_LINK 0
`define PSR_PA_RFAULT 13
`define PSR_EC_OVERRIDE 15
`define PSR_TO_JAB_EN 5
`define PSR_IRQ_AN_CPLT 0
`define PSR_IRQ_RFAULT 1
`define PSR_IRQ_LINK_DROP 2
`define PSR_IRQ_JABBER 3

// ----------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------
`define PSR_RST_JAB_EN 1'h1
`define PSR_RST_OVERRIDE 1'h0
`define PSR_RST_IRQ_MASK 4'h0
`define PSR_RESP_OKAY 2'h0
`define PSR_RESP_SLVERR 2'h2

`endif

// ==== psr_pkg.sv ====
package psr_pkg;
    // Bus slave: take a request, then answer it
    typedef enum logic {
        PSR_BUS_IDLE,
        PSR_BUS_ACK
    } psr_bus_st_t;

    // Link monitor state
    typedef enum logic {
        PSR_LINK_DOWN,
        PSR_LINK_UP
    } psr_link_st_t;
endpackage

// ==== psr_regs.sv ====
`timescale 1ns/1ps
`include "psr_cfg.svh"

// Function
// - AN complete held zero while AN disabled
// - AN complete set when negotiation finishes
// - AN complete latches; restart does not clear
// - Link code word remote fault sets status
// - One remote fault bit, cleared reading 1/17
// - Partner copy refreshed on each code word
// - AN ability bit reads one
// - Link status latches low, mirrored at 17.0
// - Link monitor decides validity from receivers
// - Jabber enable zero forces jabber bit zero
// - Jabber enable one sets on jabber condition
// - Jabber latches high, cleared reading 1/17
// - Extended capability bit always reads one
// - Identifier holds OUI, model, revision parts
// - Identifier readable; writes need override bit
// - Identifier high holds OUI bits 3 to 18
// - Status register sits at address 0x01
// - Override clear discards writes to such bits

module psr_regs #(
    // Reset value of the identifier high word; value is arbitrary
    parameter logic [15:0] ID_HIGH_RST = 16'h1234,
    parameter int ADDR_W = 8
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic [1:0] avs_response_o,
    output logic irq_o,
    input wire logic an_enable_i,
    input wire logic an_done_i,
    input wire logic lcw_valid_i,
    input wire logic lcw_rfault_i,
    input wire logic speed100_i,
    input wire logic rx10_link_i,
    input wire logic rx100_link_i,
    input wire logic link_err_i,
    input wire logic jabber_i,
    output logic jabber_en_o,
    output logic override_en_o
);
    import psr_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Byte-enable merge into a 16-bit register
    function automatic logic [15:0] be_merge(
        input logic [15:0] old_v,
        input logic [15:0] new_v,
        input logic [1:0] be
    );
        return {be[1] ? new_v[15:8] : old_v[15:8],
                be[0] ? new_v[7:0] : old_v[7:0]};
    endfunction

    // Latching-high update: set wins over a read clear
    function automatic logic latch_high(
        input logic cur,
        input logic cond,
        input logic clr
    );
        return cond | (cur & ~clr);
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    psr_bus_st_t bus_st_r;
    psr_link_st_t link_st_r;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [1:0] resp_r;
    logic [1:0] resp_nxt;
    logic irq_r;
    logic an_cplt_r;
    logic rfault_r;
    logic partner_rf_r;
    logic link_r;
    logic jabber_r;
    logic jab_en_r;
    logic override_r;
    logic [15:0] id_high_r;
    logic [3:0] irq_stat_r;
    logic [3:0] irq_mask_r;
    logic an_cplt_d_r;
    logic link_live_d_r;
    logic [ADDR_W-1:0] word_idx;
    logic take;
    logic wr_take;
    logic rd_take;
    logic rd_status;
    logic rd_detail;
    logic rd_irq;
    logic st_clr;
    logic link_live;
    logic rx_link;
    logic [3:0] irq_evt;

    // ------------------------------------------------------------
    // Avalon-MM slave sequencing
    // ------------------------------------------------------------

    // Word index; low two address bits are dropped
    assign word_idx = avs_address_i >> 2;

    // A request is taken only in idle, so it is never taken twice
    assign take = (bus_st_r == PSR_BUS_IDLE) &&
                  (avs_read_i || avs_write_i);
    assign wr_take = take && avs_write_i;
    assign rd_take = take && avs_read_i && !avs_write_i;

    // Read side effects act at the taking edge
    assign rd_status = rd_take && (word_idx == `PSR_IDX_STATUS);
    assign rd_detail = rd_take && (word_idx == `PSR_IDX_DETAIL);
    assign rd_irq = rd_take && (word_idx == `PSR_IDX_IRQ_STATUS);
    assign st_clr = rd_status || rd_detail;

    // Idle takes; ack answers for one cycle
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bus_st_r <= PSR_BUS_IDLE;
        end else begin
            case (bus_st_r)
                PSR_BUS_IDLE: begin
                    if (take) begin
                        bus_st_r <= PSR_BUS_ACK;
                    end
                end
                PSR_BUS_ACK: begin
                    bus_st_r <= PSR_BUS_IDLE;
                end
                default: begin
                    bus_st_r <= PSR_BUS_IDLE;
                end
            endcase
        end
    end

    // Read data mux and answer code; unmapped words give SLVERR
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        resp_nxt = `PSR_RESP_OKAY;
        if (word_idx == `PSR_IDX_STATUS) begin
            rdata_nxt[`PSR_ST_AN_CPLT] = an_cplt_r;
            rdata_nxt[`PSR_ST_RFAULT] = rfault_r;
            rdata_nxt[`PSR_ST_AN_ABLE] = 1'b1;
            rdata_nxt[`PSR_ST_LINK] = link_r;
            rdata_nxt[`PSR_ST_JABBER] = jabber_r;
            rdata_nxt[`PSR_ST_EXT_CAP] = 1'b1;
        end else if (word_idx == `PSR_IDX_ID_HIGH) begin
            rdata_nxt[15:0] = id_high_r;
        end else if (word_idx == `PSR_IDX_PARTNER) begin
            rdata_nxt[`PSR_PA_RFAULT] = partner_rf_r;
        end else if (word_idx == `PSR_IDX_EXT_CTRL) begin
            rdata_nxt[`PSR_EC_OVERRIDE] = override_r;
        end else if (word_idx == `PSR_IDX_DETAIL) begin
            rdata_nxt[`PSR_DT_JABBER] = jabber_r;
            rdata_nxt[`PSR_DT_RFAULT] = rfault_r;
            rdata_nxt[`PSR_DT_LINK] = link_r;
        end else if (word_idx == `PSR_IDX_TEN_OPS) begin
            rdata_nxt[`PSR_TO_JAB_EN] = jab_en_r;
        end else if (word_idx == `PSR_IDX_IRQ_STATUS) begin
            rdata_nxt[3:0] = irq_stat_r;
        end else if (word_idx == `PSR_IDX_IRQ_MASK) begin
            rdata_nxt[3:0] = irq_mask_r;
        end else begin
            resp_nxt = `PSR_RESP_SLVERR;
        end
        if (!rd_take) begin
            rdata_nxt = 32'h0000_0000;
        end
    end

    // Answer registers; read data is the value before any clear
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_r <= 32'h0000_0000;
            resp_r <= `PSR_RESP_OKAY;
        end else if (take) begin
            rdata_r <= rdata_nxt;
            resp_r <= resp_nxt;
        end
    end

    // ------------------------------------------------------------
    // Software controlled bits
    // ------------------------------------------------------------

    // Override and jabber enable are always writable
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            override_r <= `PSR_RST_OVERRIDE;
            jab_en_r <= `PSR_RST_JAB_EN;
        end else if (wr_take) begin
            if ((word_idx == `PSR_IDX_EXT_CTRL) && avs_byteenable_i[1]) begin
                override_r <= avs_writedata_i[`PSR_EC_OVERRIDE];
            end
            if ((word_idx == `PSR_IDX_TEN_OPS) && avs_byteenable_i[0]) begin
                jab_en_r <= avs_writedata_i[`PSR_TO_JAB_EN];
            end
        end
    end

    // Identifier high word: writes land only with override set
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            id_high_r <= ID_HIGH_RST;
        end else if (wr_take && (word_idx == `PSR_IDX_ID_HIGH) &&
                     override_r) begin
            id_high_r <= be_merge(id_high_r, avs_writedata_i[15:0],
                                  avs_byteenable_i[1:0]);
        end
    end

    // Interrupt mask, byte lane 0 only
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_mask_r <= `PSR_RST_IRQ_MASK;
        end else if (wr_take && (word_idx == `PSR_IDX_IRQ_MASK) &&
                     avs_byteenable_i[0]) begin
            irq_mask_r <= avs_writedata_i[3:0];
        end
    end

    // ------------------------------------------------------------
    // Link monitor
    // ------------------------------------------------------------

    // Observe the receiver of the active speed
    assign rx_link = speed100_i ? rx100_link_i : rx10_link_i;

    // Coming up needs negotiation done if enabled; staying up
    // needs only a clean receiver, so a restart keeps the link.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            link_st_r <= PSR_LINK_DOWN;
        end else begin
            case (link_st_r)
                PSR_LINK_DOWN: begin
                    if (rx_link && !link_err_i &&
                        (!an_enable_i || an_done_i)) begin
                        link_st_r <= PSR_LINK_UP;
                    end
                end
                PSR_LINK_UP: begin
                    if (!rx_link || link_err_i) begin
                        link_st_r <= PSR_LINK_DOWN;
                    end
                end
                default: begin
                    link_st_r <= PSR_LINK_DOWN;
                end
            endcase
        end
    end

    assign link_live = (link_st_r == PSR_LINK_UP);

    // ------------------------------------------------------------
    // Latched status bits
    // ------------------------------------------------------------

    // Negotiation complete: zero while disabled, latches high;
    // only a read releases it, never a restart
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            an_cplt_r <= 1'b0;
        end else if (!an_enable_i) begin
            an_cplt_r <= 1'b0;
        end else begin
            an_cplt_r <= latch_high(an_cplt_r, an_done_i,
                                    st_clr);
        end
    end

    // Remote fault: one internal bit behind both status words
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rfault_r <= 1'b0;
        end else begin
            rfault_r <= latch_high(rfault_r,
                                   lcw_valid_i && lcw_rfault_i,
                                   st_clr);
        end
    end

    // Partner copy follows each code word, no latching
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            partner_rf_r <= 1'b0;
        end else if (lcw_valid_i) begin
            partner_rf_r <= lcw_rfault_i;
        end
    end

    // Link status latches low; a read releases it
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            link_r <= 1'b0;
        end else begin
            link_r <= link_live & (link_r | st_clr);
        end
    end

    // Jabber: forced low when detection is off, else latches high
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            jabber_r <= 1'b0;
        end else if (!jab_en_r) begin
            jabber_r <= 1'b0;
        end else begin
            jabber_r <= latch_high(jabber_r, jabber_i,
                                   st_clr);
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------

    // Edge history for the event detectors
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            an_cplt_d_r <= 1'b0;
            link_live_d_r <= 1'b0;
        end else begin
            an_cplt_d_r <= an_done_i && an_enable_i;
            link_live_d_r <= link_live;
        end
    end

    // Events: negotiation done, fault reported, link lost, jabber
    always_comb begin
        irq_evt = 4'h0;
        irq_evt[`PSR_IRQ_AN_CPLT] = an_done_i && an_enable_i &&
                                    !an_cplt_d_r;
        irq_evt[`PSR_IRQ_RFAULT] = lcw_valid_i && lcw_rfault_i;
        irq_evt[`PSR_IRQ_LINK_DROP] = link_live_d_r && !link_live;
        irq_evt[`PSR_IRQ_JABBER] = jab_en_r && jabber_i;
    end

    // Sticky status cleared by its own read; a new event wins
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_stat_r <= 4'h0;
        end else if (rd_irq) begin
            irq_stat_r <= irq_evt;
        end else begin
            irq_stat_r <= irq_stat_r | irq_evt;
        end
    end

    // Registered level interrupt, so it lags status by one cycle
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(irq_stat_r & irq_mask_r);
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign avs_readdata_o = rdata_r;
    assign avs_waitrequest_o = (bus_st_r != PSR_BUS_ACK);
    assign avs_response_o = resp_r;
    assign irq_o = irq_r;
    assign jabber_en_o = jab_en_r;
    assign override_en_o = override_r;

endmodule

// ==== psr_regs_props.sv ====
`timescale 1ns/1ps
`include "psr_cfg.svh"
// ----------------------------------------------------------------
// Port checks for the register bank
// ----------------------------------------------------------------
module psr_regs_props #(
    parameter int ADDR_W = 8
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic [1:0] avs_response_o,
    input wire logic an_enable_i,
    input wire logic link_err_i,
    input wire logic jabber_en_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    wire [ADDR_W-1:0] idx = avs_address_i >> 2;
    logic rd_q;
    logic map_q;
    logic [ADDR_W-1:0] idx_q;
    // Request seen at the taking edge, for the answer cycle
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_q <= 1'h0;
            map_q <= 1'h0;
            idx_q <= '0;
        end else begin
            rd_q <= avs_read_i && !avs_write_i;
            idx_q <= idx;
            map_q <= idx inside {`PSR_IDX_STATUS, `PSR_IDX_ID_HIGH,
                `PSR_IDX_PARTNER, `PSR_IDX_EXT_CTRL, `PSR_IDX_DETAIL,
                `PSR_IDX_TEN_OPS, `PSR_IDX_IRQ_STATUS, `PSR_IDX_IRQ_MASK};
        end
    end
    // Status read answered in this cycle
    wire st_ack = !avs_waitrequest_o && rd_q && idx_q == `PSR_IDX_STATUS;

    a_ack_one_cycle: assert property (
        !avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("ack longer than one cycle");
    a_ack_in_time: assert property (
        $rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o)
        else $error("late answer");
    a_status_const: assert property (
        st_ack |-> avs_readdata_o[`PSR_ST_AN_ABLE]
            && avs_readdata_o[`PSR_ST_EXT_CAP])
        else $error("constant bits not one");
    a_an_off_zero: assert property (
        st_ack && !$past(an_enable_i) && !$past(an_enable_i, 2)
        |-> !avs_readdata_o[`PSR_ST_AN_CPLT])
        else $error("an complete while disabled");
    a_jab_off_zero: assert property (
        st_ack && !$past(jabber_en_o) && !$past(jabber_en_o, 2)
        |-> !avs_readdata_o[`PSR_ST_JABBER])
        else $error("jabber while disabled");
    a_link_err_low: assert property (
        st_ack && $past(link_err_i, 3) |-> !avs_readdata_o[`PSR_ST_LINK])
        else $error("link high after error");
    a_unmapped_err: assert property (
        !avs_waitrequest_o && !map_q |-> avs_response_o == `PSR_RESP_SLVERR
            && (!rd_q || avs_readdata_o == 32'h0))
        else $error("unmapped not refused");
    a_mapped_okay: assert property (
        !avs_waitrequest_o && map_q |-> avs_response_o == `PSR_RESP_OKAY)
        else $error("mapped refused");
    a_upper_zero: assert property (
        !avs_waitrequest_o && rd_q |-> avs_readdata_o[31:16] == 16'h0)
        else $error("upper data not zero");
endmodule

// ==== psr_sta_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Management station model
// ----------------------------------------------------------------
module psr_sta_model (
    input wire logic clk_i,
    output logic [7:0] avs_address_o,
    output logic avs_read_o,
    output logic avs_write_o,
    output logic [31:0] avs_writedata_o,
    output logic [3:0] avs_byteenable_o,
    input wire logic [31:0] avs_readdata_i,
    input wire logic avs_waitrequest_i,
    input wire logic [1:0] avs_response_i,
    output logic hang_o
);
    // Idle bus starts quiet
    initial begin
        avs_address_o = 8'h00;
        avs_read_o = 1'h0;
        avs_write_o = 1'h0;
        avs_writedata_o = 32'h0;
        avs_byteenable_o = 4'h3;
        hang_o = 1'h0;
    end
    // One transfer, held until waitrequest is seen low
    task automatic xfer(input logic wr, input logic [7:0] idx,
        input logic [15:0] wd, output logic [15:0] rd,
        output logic [1:0] resp);
        int n;
        n = 0;
        @(posedge clk_i);
        avs_address_o <= {idx[5:0], 2'h0};
        avs_read_o <= !wr;
        avs_write_o <= wr;
        avs_writedata_o <= {16'h0, wd};
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_i !== 1'h0 && n < 50);
        if (n >= 50) begin
            hang_o <= 1'h1;
        end
        rd = avs_readdata_i[15:0];
        resp = avs_response_i;
        // Released lines change so stale values cannot pass
        avs_read_o <= 1'h0;
        avs_write_o <= 1'h0;
        avs_address_o <= ~avs_address_o;
        avs_writedata_o <= ~avs_writedata_o;
    endtask
endmodule

// ==== psr_regs_tb.sv ====
`timescale 1ns/1ps
`include "psr_cfg.svh"
module psr_regs_tb;
    localparam logic [15:0] ID_RST = 16'h1234; // Arbitrary value
    logic clk_i, resetn_i, an_enable_i, an_done_i, lcw_valid_i;
    logic lcw_rfault_i, speed100_i, rx10_link_i, rx100_link_i;
    logic link_err_i, jabber_i, avs_read_i, avs_write_i;
    logic avs_waitrequest_o, irq_o, hang;
    logic [7:0] avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o;
    logic [3:0] avs_byteenable_i;
    logic [1:0] avs_response_o;
    int fail_count = 0;
    int cmp_count = 0;
    psr_regs #(.ID_HIGH_RST(ID_RST), .ADDR_W(8)) psr_regs_inst (
        .clk_i(clk_i), .resetn_i(resetn_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o),
        .avs_response_o(avs_response_o), .irq_o(irq_o),
        .an_enable_i(an_enable_i), .an_done_i(an_done_i),
        .lcw_valid_i(lcw_valid_i), .lcw_rfault_i(lcw_rfault_i),
        .speed100_i(speed100_i), .rx10_link_i(rx10_link_i),
        .rx100_link_i(rx100_link_i), .link_err_i(link_err_i),
        .jabber_i(jabber_i), .jabber_en_o(), .override_en_o());
    psr_sta_model psr_sta_model_inst (
        .clk_i(clk_i), .avs_address_o(avs_address_i),
        .avs_read_o(avs_read_i), .avs_write_o(avs_write_i),
        .avs_writedata_o(avs_writedata_i),
        .avs_byteenable_o(avs_byteenable_i),
        .avs_readdata_i(avs_readdata_o),
        .avs_waitrequest_i(avs_waitrequest_o),
        .avs_response_i(avs_response_o), .hang_o(hang));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
        input string msg);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s seen %h expected %h",
                $time, msg, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // Read, compare masked data, require OKAY
    task automatic rd(input logic [7:0] idx, input logic [15:0] m,
        input logic [15:0] e, input string msg);
        logic [15:0] d;
        logic [1:0] r;
        psr_sta_model_inst.xfer(1'h0, idx, 16'h0, d, r);
        chk({14'h0, r, d & m}, {14'h0, `PSR_RESP_OKAY, e}, msg);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [15:0] v);
        logic [15:0] d;
        logic [1:0] r;
        psr_sta_model_inst.xfer(1'h1, idx, v, d, r);
    endtask
    // One partner code word; flag inverted outside it
    task automatic lcw(input logic f);
        @(posedge clk_i);
        lcw_valid_i <= 1'h1;
        lcw_rfault_i <= f;
        @(posedge clk_i);
        lcw_valid_i <= 1'h0;
        lcw_rfault_i <= ~f;
    endtask
    task automatic jab();
        @(posedge clk_i);
        jabber_i <= 1'h1;
        @(posedge clk_i);
        jabber_i <= 1'h0;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd(`PSR_IDX_STATUS, 16'hFFFF, 16'h0009, "status");
        rd(`PSR_IDX_ID_HIGH, 16'hFFFF, ID_RST, "id reset");
        rd(`PSR_IDX_TEN_OPS, 16'h0020, 16'h0020, "jab en");
        rd(`PSR_IDX_EXT_CTRL, 16'h8000, 16'h0000, "override");
        rd(`PSR_IDX_IRQ_MASK, 16'h000F, 16'h0000, "mask reset");
    endtask
    task automatic t_id();
        logic [15:0] d;
        logic [1:0] r;
        wr(`PSR_IDX_ID_HIGH, 16'hA5C3);
        rd(`PSR_IDX_ID_HIGH, 16'hFFFF, ID_RST, "id locked");
        wr(`PSR_IDX_EXT_CTRL, 16'h8000);
        wr(`PSR_IDX_ID_HIGH, 16'hA5C3);
        rd(`PSR_IDX_ID_HIGH, 16'hFFFF, 16'hA5C3, "id open");
        wr(`PSR_IDX_EXT_CTRL, 16'h0000);
        wr(`PSR_IDX_ID_HIGH, 16'h0F0F);
        rd(`PSR_IDX_ID_HIGH, 16'hFFFF, 16'hA5C3, "id relock");
        wr(`PSR_IDX_STATUS, 16'h0000);
        rd(`PSR_IDX_STATUS, 16'h0009, 16'h0009, "status ro");
        psr_sta_model_inst.xfer(1'h0, 8'h3F, 16'h0, d, r);
        chk({r, d}, {`PSR_RESP_SLVERR, 16'h0}, "unmapped");
    endtask
    task automatic t_an();
        an_done_i <= 1'h1;
        tick(3);
        rd(`PSR_IDX_STATUS, 16'h0020, 16'h0000, "an off");
        an_enable_i <= 1'h1;
        an_done_i <= 1'h0;
        tick(3);
        rd(`PSR_IDX_STATUS, 16'h0020, 16'h0000, "an busy");
        an_done_i <= 1'h1;
        tick(2);
        an_done_i <= 1'h0;
        tick(2);
        rd(`PSR_IDX_STATUS, 16'h0020, 16'h0020, "an held");
        rd(`PSR_IDX_STATUS, 16'h0020, 16'h0000, "an live");
        an_enable_i <= 1'h0;
    endtask
    task automatic t_rf();
        lcw(1'h1);
        rd(`PSR_IDX_PARTNER, 16'h2000, 16'h2000, "copy");
        rd(`PSR_IDX_DETAIL, 16'h0002, 16'h0002, "rf detail");
        rd(`PSR_IDX_STATUS, 16'h0010, 16'h0000, "rf shared");
        lcw(1'h0);
        rd(`PSR_IDX_PARTNER, 16'h2000, 16'h0000, "copy0");
        rd(`PSR_IDX_STATUS, 16'h0010, 16'h0000, "rf zero");
        lcw(1'h1);
        lcw(1'h0);
        rd(`PSR_IDX_STATUS, 16'h0010, 16'h0010, "rf held");
        rd(`PSR_IDX_DETAIL, 16'h0002, 16'h0000, "rf clr");
    endtask
    task automatic t_jab();
        jab();
        rd(`PSR_IDX_STATUS, 16'h0002, 16'h0002, "jab");
        rd(`PSR_IDX_DETAIL, 16'h0004, 16'h0000, "jab clr");
        jab();
        rd(`PSR_IDX_DETAIL, 16'h0004, 16'h0004, "jab det");
        rd(`PSR_IDX_STATUS, 16'h0002, 16'h0000, "jab clr2");
        wr(`PSR_IDX_TEN_OPS, 16'h0000);
        jab();
        rd(`PSR_IDX_STATUS, 16'h0002, 16'h0000, "jab off");
        wr(`PSR_IDX_TEN_OPS, 16'h0020);
    endtask
    task automatic t_link();
        speed100_i <= 1'h1;
        rx100_link_i <= 1'h1;
        tick(3);
        rd(`PSR_IDX_STATUS, 16'h0004, 16'h0000, "up held");
        rd(`PSR_IDX_DETAIL, 16'h0001, 16'h0001, "up mirror");
        link_err_i <= 1'h1;
        tick(1);
        link_err_i <= 1'h0;
        rd(`PSR_IDX_STATUS, 16'h0004, 16'h0000, "drop");
        rd(`PSR_IDX_STATUS, 16'h0004, 16'h0004, "relive");
        speed100_i <= 1'h0;
        tick(3);
        rd(`PSR_IDX_STATUS, 16'h0004, 16'h0000, "rx10 down");
        rx10_link_i <= 1'h1;
        tick(3);
        rd(`PSR_IDX_DETAIL, 16'h0001, 16'h0000, "rx10 held");
        rd(`PSR_IDX_STATUS, 16'h0004, 16'h0004, "rx10 up");
    endtask
    task automatic t_irq();
        rd(`PSR_IDX_IRQ_STATUS, 16'h0000, 16'h0000, "flush");
        wr(`PSR_IDX_IRQ_MASK, 16'h0008);
        jab();
        tick(2);
        chk({31'h0, irq_o}, 32'h1, "irq up");
        rd(`PSR_IDX_IRQ_STATUS, 16'h000F, 16'h0008, "irq st");
        tick(2);
        chk({31'h0, irq_o}, 32'h0, "irq clr");
        wr(`PSR_IDX_IRQ_MASK, 16'h0004);
        jab();
        tick(2);
        chk({31'h0, irq_o}, 32'h0, "irq mask");
        link_err_i <= 1'h1;
        tick(1);
        link_err_i <= 1'h0;
        tick(3);
        chk({31'h0, irq_o}, 32'h1, "irq link");
        rd(`PSR_IDX_IRQ_STATUS, 16'h000F, 16'h000C, "irq both");
    endtask
    // ------------------------------------------------------------
    // Clock, reset and sequence
    // ------------------------------------------------------------
    initial begin
        clk_i = 1'h0;
        forever #10 clk_i = ~clk_i;
    end
    // Engine inputs start idle with the link down
    initial begin
        resetn_i = 1'h0;
        {an_enable_i, an_done_i, lcw_valid_i, lcw_rfault_i, speed100_i,
            rx10_link_i, rx100_link_i, link_err_i, jabber_i} = 9'h000;
        repeat (20) @(posedge clk_i);
        resetn_i <= 1'h1;
        tick(2);
        t_reset();
        t_id();
        t_an();
        t_rf();
        t_jab();
        t_link();
        t_irq();
        report_and_stop();
    end
    // A timed-out bus wait ends the run
    always @(posedge hang) begin
        fail_count++;
        report_and_stop();
    end
endmodule

bind psr_regs psr_regs_props #(.ADDR_W(ADDR_W)) psr_regs_props_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .avs_response_o(avs_response_o), .an_enable_i(an_enable_i),
    .link_err_i(link_err_i), .jabber_en_o(jabber_en_o));
